// >>> bench/oscc_plant.sv
// Far-side model: output drivers reporting mute, and a reference clock.
// Assumes mute_i comes from the controller on the same clock.
module oscc_plant (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [5:0] mute_i,
  input  wire logic       slow_i,
  input  wire logic       ref_run_i,
  output logic      [1:0] drivers_muted_o,
  output logic      [1:0] ref_clk_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [1:0][4:0] age;
  logic [2:0]      div;
  // ==========================================================
  // Driver mute settling and reference divider
  // Reference stands still when stopped, so no rising edge can leak out
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      age       <= '0;
      div       <= 3'h0;
      ref_clk_o <= 2'h0;
    end else begin
      for (int c = 0; c < 2; c++) begin
        if (mute_i[3*c +: 3] == 3'h0) age[c] <= 5'h00;
        else if (age[c] != 5'h1f) age[c] <= age[c] + 5'h01;
      end
      if (ref_run_i) begin
        div <= (div == 3'h2) ? 3'h0 : div + 3'h1;
        if (div == 3'h2) ref_clk_o <= ~ref_clk_o;
      end
    end
  end
  // mute status report
  // A slow driver takes twelve cycles, so the confirm wait is exercised
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      drivers_muted_o[c] = age[c] >= (slow_i ? 5'h0c : 5'h01);
    end
  end
endmodule

// >>> bench/test_oscc_top.sv
// Self-checking bench for the output clock sync controller.
// Assumes the plant model answers the mute and reference side.
`include "oscc_consts.svh"
module test_oscc_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, ack;
  logic [15:0] adr = 16'h0000;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat;
  logic        lock = 1'b0, mall = 1'b0, eep = 1'b0;
  logic        slow = 1'b0, ref_run = 1'b1;
  logic [1:0]  analog_upconversion_pll = 2'h3, phase = 2'h0, freq = 2'h0, hitless = 2'h3;
  logic [1:0]  mpin = 2'h0, muted, refc, busy, prst;
  logic [5:0]  mute, qrst;
  logic [7:0]  qr0, qr1, q;
  int          failures = 0;
  int          checked = 0;

  // Free-running system clock, 4 ns period
  always #2 clk_i = ~clk_i;

  oscc_top u_oscc_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .system_clock_locked_i(lock), .analog_upconversion_pll_ready_i(analog_upconversion_pll),
    .digital_tracking_pll_phase_i(phase), .digital_tracking_pll_freq_i(freq),
    .hitless_valid_i(hitless), .drivers_muted_i(muted), .ref_clk_i(refc),
    .multifunction_pin_all_i(mall), .multifunction_pin_ch_i(mpin),
    .eeprom_sync_i(eep), .clock_output_mute_o(mute), .p_div_reset_o(prst),
    .q_div_reset_o(qrst), .q_ratio0_o(qr0), .q_ratio1_o(qr1),
    .seq_busy_o(busy));
  oscc_plant u_oscc_plant (.clk_i(clk_i), .rst_i(rst_i), .mute_i(mute),
    .slow_i(slow), .ref_run_i(ref_run), .drivers_muted_o(muted),
    .ref_clk_o(refc));

  // ==========================================================
  // Shared tasks
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // One classic Wishbone cycle; read data lands in q
  task wb(input logic w, input logic [13:0] idx, input logic [7:0] d);
    int n;
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; sel <= 4'h1;
    adr <= {idx, 2'b00}; wdat <= {24'h0, d};
    n = 0;
    do begin @(posedge clk_i); n++; end while (ack !== 1'b1 && n < 50);
    chk({31'h0, ack}, 32'h1);
    q = rdat[7:0];
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask
  task cyc_n(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  task wait_busy(input logic [1:0] exp);
    int n;
    n = 0;
    while (busy !== exp && n < 2000) begin @(posedge clk_i); n++; end
    chk(busy, exp);
  endtask
  task pulse_eep;
    @(posedge clk_i); eep <= 1'b1;
    @(posedge clk_i); eep <= 1'b0;
  endtask

  // ==========================================================
  // Scenarios
  task t_reset;
    chk(mute, 6'h3f);
    chk(qrst, 6'h3f);
    chk(busy, 2'h0);
    chk(prst, 2'h3);
    wb(1'b0, `OSCC_CH0_CFG_IDX, 8'h00); chk(q, 8'h00);
    wb(1'b0, 14'h0100, 8'h00); chk(q, 8'h00);
  endtask
  task t_nolock;
    pulse_eep; cyc_n(20); chk(busy, 2'h0);
    lock <= 1'b1; cyc_n(5);
    wb(1'b1, `OSCC_CH0_QRATIO_IDX, 8'h03); wb(1'b1, `OSCC_UPDATE_IDX, 8'h01);
    cyc_n(20); chk(busy, 2'h0);
  endtask
  task t_manual;
    wb(1'b1, `OSCC_GLOBAL_IDX, 8'h08); wait_busy(2'h3);
    cyc_n(30); chk(busy, 2'h3);
    chk(prst, 2'h3);
    analog_upconversion_pll <= 2'h2;
    wb(1'b1, `OSCC_GLOBAL_IDX, 8'h00);
    cyc_n(30); chk(busy, 2'h1);
    analog_upconversion_pll <= 2'h3; wait_busy(2'h0);
    chk(mute, 6'h00);
    chk(qrst, 6'h00);
    chk(qr0, 8'h03);
  endtask
  task t_chan;
    slow <= 1'b1;
    wb(1'b1, `OSCC_CH1_CTRL_IDX, 8'h08); wait_busy(2'h2);
    cyc_n(40); chk(mute, 6'h38);
    chk(prst, 2'h2);
    wb(1'b1, `OSCC_CH1_CTRL_IDX, 8'h00); wait_busy(2'h0);
    chk(mute, 6'h00);
    slow <= 1'b0;
    mpin <= 2'h1; wait_busy(2'h1);
    cyc_n(20); chk(qrst, 6'h07);
    mpin <= 2'h0; wait_busy(2'h0);
    mall <= 1'b1; wait_busy(2'h3);
    mall <= 1'b0; wait_busy(2'h0);
  endtask
  task t_reconf;
    analog_upconversion_pll <= 2'h0;
    wb(1'b1, `OSCC_SRC_EN_IDX, 8'h01); wb(1'b1, `OSCC_MASK_IDX, 8'h01);
    wb(1'b1, `OSCC_CH0_QRATIO_IDX, 8'h09); wb(1'b1, `OSCC_UPDATE_IDX, 8'h01);
    wait_busy(2'h1); cyc_n(20);
    chk(mute, 6'h06);
    chk(qrst, 6'h06);
    analog_upconversion_pll <= 2'h3; wait_busy(2'h0);
    chk(qr0, 8'h09);
    wb(1'b1, `OSCC_SRC_EN_IDX, 8'h00); wb(1'b1, `OSCC_MASK_IDX, 8'h00);
    analog_upconversion_pll <= 2'h1;
    wb(1'b1, `OSCC_CH1_QRATIO_IDX, 8'h05); wb(1'b1, `OSCC_UPDATE_IDX, 8'h01);
    wait_busy(2'h2); cyc_n(20); chk(mute, 6'h38);
    analog_upconversion_pll <= 2'h3; wait_busy(2'h0);
    chk(qr1, 8'h05);
  endtask
  task t_auto;
    for (int m = 1; m < 4; m++) begin
      phase <= 2'h0; freq <= 2'h0;
      wb(1'b1, `OSCC_CH0_CFG_IDX, m[7:0]);
      cyc_n(10); chk(busy, 2'h0);
      wb(1'b1, `OSCC_UPDATE_IDX, 8'h01);
      // Immediate mode fires on the update itself, so no settle gap there
      if (m > 1) begin
        cyc_n(20);
        chk(busy, 2'h0);
        phase <= 2'h3;
        freq <= 2'h3;
      end
      wait_busy(2'h1); wait_busy(2'h0);
      cyc_n(20); chk(busy, 2'h0);
    end
    wb(1'b1, `OSCC_CH0_REARM_IDX, 8'h01); wait_busy(2'h1);
    wait_busy(2'h0);
    wb(1'b1, `OSCC_CH0_CFG_IDX, 8'h00); wb(1'b1, `OSCC_UPDATE_IDX, 8'h01);
    wb(1'b1, `OSCC_CH0_REARM_IDX, 8'h01);
    cyc_n(20); chk(busy, 2'h0);
  endtask
  task t_ref;
    hitless <= 2'h0;
    wb(1'b1, `OSCC_CH0_CFG_IDX, 8'h04); wb(1'b1, `OSCC_UPDATE_IDX, 8'h01);
    ref_run <= 1'b0; pulse_eep; cyc_n(20);
    chk(busy, 2'h3);
    chk(mute, 6'h00);
    hitless <= 2'h3; cyc_n(60);
    chk(busy, 2'h1);
    ref_run <= 1'b1; wait_busy(2'h0);
    chk(mute, 6'h00);
    wb(1'b0, `OSCC_CH0_CFG_IDX, 8'h00); chk(q, 8'h04);
  endtask
  // Mid-run reset: outputs held again, ratio change no longer triggers
  task t_rereset;
    rst_i <= 1'b1;
    cyc_n(4);
    rst_i <= 1'b0;
    cyc_n(3);
    chk(mute, 6'h3f);
    chk(qrst, 6'h3f);
    chk(prst, 2'h3);
    chk(qr0, 8'h00);
    wb(1'b1, `OSCC_CH0_QRATIO_IDX, 8'h07);
    wb(1'b1, `OSCC_UPDATE_IDX, 8'h01);
    cyc_n(20);
    chk(busy, 2'h0);
    chk(qrst, 6'h3f);
  endtask

  // ==========================================================
  // Verdict and sequence
  task end_sim;
    $display("Comparisons %0d, mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Whole run is under a thousand cycles; this bound is far beyond it
  initial begin
    #200000;
    failures++;
    end_sim;
  end
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    cyc_n(3);
    t_reset;
    t_nolock;
    t_manual;
    t_chan;
    t_reconf;
    t_auto;
    t_ref;
    t_rereset;
    end_sim;
  end
endmodule

// >>> hw/oscc_align_timer.sv
// Down counter that delays output release after a reference edge.
// Assumes start_i is a one-cycle pulse from the same clock.
`include "oscc_consts.svh"
module oscc_align_timer (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic start_i,
  output logic      done_o
);
  oscc_pkg::oscc_tmr_t s;
  oscc_pkg::oscc_tmr_t next_s;

  // Load on start, count down to zero
  always_comb begin
    next_s = s;
    if (start_i) begin
      next_s.cnt = 4'(`OSCC_ALIGN_CYC);
    end else if (s.cnt != 4'h0) begin
      next_s.cnt = s.cnt - 4'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // Last counted cycle; a restart mid-count wins
  assign done_o = (s.cnt == 4'h1) & ~start_i;
endmodule

// >>> hw/oscc_consts.svh
// Constants for the output clock sync controller: map, fields, timing.
// Assumes a 250 MHz system clock and a Wishbone word-per-register map.
// Behaviour
// - After reset every output divider stays in reset until a sync trigger.
// - Triggers come from manual bits, pins, EEPROM, autoreconfig or autosync.
// - Triggers hit one channel; global bit, all-channel pin and EEPROM start both, unaligned.
// - With reference sync on either channel, wait for hitless before muting.
// - Confirm drivers muted, then reset P and Q dividers to load settings.
// - Reference sync aligns release to reference edge, else await manual clear; the code awaits the clear for manual syncs either way.
// - Before release wait for analog PLL calibrated and locked.
// - Finally unmute drivers, release Q dividers, return to waiting.
// - No sequence starts unless the system clock is locked.
// - Manual trigger stalls before unmute until host clears the bit.
// - Multifunction input pins trigger the same manual syncs as the bits.
// - Q ratio change plus update strobe triggers, only after first sync.
// - Autoreconfig resyncs the unprotected outputs of its channel, muted, glitch free.
// - Outputs with clock source enable and sync mask set stay undisturbed; the code spares them in autoreconfig only, other syncs mute and reset them.
// - Per-channel 2-bit autosync mode: off, immediate, phase, frequency lock.
// - Autosync waits for system clock lock then the selected event.
// - Autosync fires once; rearm bit or mode rewrite arms it again.
// - Mode zero leaves only manual and autoreconfig triggers.
// - Reference sync leaves a small fixed offset of about 30 ns.
// - Reference sync enable resets to 0; it gates its own channel's edge wait and both channels' hitless wait.
`ifndef OSCC_CONSTS_SVH
`define OSCC_CONSTS_SVH
// ==========================================================
// Register indices (byte address is four times the index)
`define OSCC_CH0_CFG_IDX    14'h10db
`define OSCC_CH1_CFG_IDX    14'h14db
`define OSCC_GLOBAL_IDX     14'h2000
`define OSCC_CH0_CTRL_IDX   14'h2101
`define OSCC_CH0_REARM_IDX  14'h2107
`define OSCC_CH1_CTRL_IDX   14'h2201
`define OSCC_CH1_REARM_IDX  14'h2207
`define OSCC_UPDATE_IDX     14'h000f
`define OSCC_CH0_QRATIO_IDX 14'h3000
`define OSCC_CH1_QRATIO_IDX 14'h3001
`define OSCC_SRC_EN_IDX     14'h3002
`define OSCC_MASK_IDX       14'h3003
`define OSCC_STATUS_IDX     14'h3004
// ==========================================================
// Field positions and codes
`define OSCC_REFSYNC_BIT 2
`define OSCC_SYNC_BIT    3
`define OSCC_REARM_BIT   0
`define OSCC_UPDATE_BIT  0
`define OSCC_MODE_OFF    2'h0
`define OSCC_MODE_IMM    2'h1
`define OSCC_MODE_PHASE  2'h2
`define OSCC_MODE_FREQ   2'h3
`define OSCC_OUT_PER_CH  3
`define OSCC_SYNC_W      16
// ==========================================================
// Timing
`define OSCC_CLK_PS       4000
`define OSCC_REF_ALIGN_NS 30
`define OSCC_ALIGN_CYC \
  ((`OSCC_REF_ALIGN_NS * 1000 + `OSCC_CLK_PS - 1) / `OSCC_CLK_PS)
`endif

// >>> hw/oscc_pkg.sv
// Types shared by the sync controller modules.
// Assumes oscc_consts.svh is on the include path.
`include "oscc_consts.svh"
package oscc_pkg;
  // ==========================================================
  // Sequencer states
  typedef enum logic [3:0] {
    ST_IDLE, ST_HITLESS, ST_MUTE, ST_CONFIRM, ST_RESET,
    ST_RELEASE, ST_ANALOG_UPCONVERSION_PLL, ST_EDGE, ST_ALIGN, ST_UNMUTE
  } oscc_seq_t;

  // Whole state of the top module
  typedef struct packed {
    oscc_seq_t [1:0] st;
    logic [1:0]      manual;
    logic [1:0]      reconf;
    logic [1:0]      armed;
    logic [1:0]      man_prev;
    logic [1:0]      chsync;
    logic            first_done;
    logic            glob;
    logic            ack;
    logic [1:0][7:0] cfg_stg;
    logic [1:0][7:0] cfg;
    logic [1:0][7:0] qr_stg;
    logic [1:0][7:0] qr;
    logic [5:0]      src_en;
    logic [5:0]      sync_mask;
    logic [5:0]      mute;
    logic [5:0]      qrst;
    logic [1:0]      prst;
    logic [7:0]      rdat;
  } oscc_state_t;

  typedef struct packed {
    logic [3:0] cnt;
  } oscc_tmr_t;

  typedef struct packed {
    logic [`OSCC_SYNC_W-1:0] s1;
    logic [`OSCC_SYNC_W-1:0] s2;
    logic [`OSCC_SYNC_W-1:0] s3;
  } oscc_sync_t;
endpackage

// >>> hw/oscc_sync.sv
// Two-flop synchroniser with rising-edge detect for pins and PLL status.
// Assumes inputs are asynchronous to clk_i; the first stage feeds only s2.
`include "oscc_consts.svh"
module oscc_sync (
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  input  wire logic [`OSCC_SYNC_W-1:0] async_i,
  output logic      [`OSCC_SYNC_W-1:0] level_o,
  output logic      [`OSCC_SYNC_W-1:0] rise_o
);
  oscc_pkg::oscc_sync_t s;
  oscc_pkg::oscc_sync_t next_s;

  // Shift chain; s3 only serves the edge detect
  always_comb begin
    next_s    = s;
    next_s.s1 = async_i;
    next_s.s2 = s.s1;
    next_s.s3 = s.s2;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign level_o = s.s2;
  assign rise_o  = s.s2 & ~s.s3;
endmodule

// >>> hw/oscc_top.sv
// Output clock sync controller: two channel sequencers and a Wishbone map.
// Assumes the drivers report mute status and PLL status arrive unsynced.
//
// Register access over Wishbone was left to the implementer.
`include "oscc_consts.svh"
module oscc_top (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [15:0] wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        system_clock_locked_i,
  input  wire logic [1:0]  analog_upconversion_pll_ready_i,
  input  wire logic [1:0]  digital_tracking_pll_phase_i,
  input  wire logic [1:0]  digital_tracking_pll_freq_i,
  input  wire logic [1:0]  hitless_valid_i,
  input  wire logic [1:0]  drivers_muted_i,
  input  wire logic [1:0]  ref_clk_i,
  input  wire logic        multifunction_pin_all_i,
  input  wire logic [1:0]  multifunction_pin_ch_i,
  input  wire logic        eeprom_sync_i,
  output logic      [5:0]  clock_output_mute_o,
  output logic      [1:0]  p_div_reset_o,
  output logic      [5:0]  q_div_reset_o,
  output logic      [7:0]  q_ratio0_o,
  output logic      [7:0]  q_ratio1_o,
  output logic      [1:0]  seq_busy_o
);
  // ==========================================================
  // Declarations
  oscc_pkg::oscc_state_t   s;
  oscc_pkg::oscc_state_t   next_s;
  logic [`OSCC_SYNC_W-1:0] sy_in;
  logic [`OSCC_SYNC_W-1:0] sy_lvl;
  logic [`OSCC_SYNC_W-1:0] sy_rise;
  logic                    lock;
  logic [1:0]              pll_ok;
  logic [1:0]              ph_lock;
  logic [1:0]              fr_lock;
  logic [1:0]              hitless;
  logic [1:0]              muted;
  logic                    pin_all;
  logic [1:0]              pin_ch;
  logic [1:0]              ref_rise;
  logic [1:0]              t_start;
  logic [1:0]              t_done;
  logic                    acc;
  logic                    wr;
  logic [13:0]             idx;
  logic [7:0]              rd;
  logic                    upd;
  logic [1:0]              rearm;
  logic [1:0]              mlvl;
  logic [1:0]              mrise;
  logic [1:0]              rcf;
  logic [1:0]              ev;
  logic [1:0]              auto_t;
  logic [1:0]              trig;
  logic [1:0]              busy;
  logic                    ref_any;
  logic [5:0]              prot_all;
  logic [1:0][2:0]         prot;

  // ==========================================================
  // Input synchronisers: status lines and pins cross from outside
  assign sy_in = {ref_clk_i, multifunction_pin_ch_i,
                  multifunction_pin_all_i, drivers_muted_i,
                  hitless_valid_i, digital_tracking_pll_freq_i,
                  digital_tracking_pll_phase_i,
                  analog_upconversion_pll_ready_i,
                  system_clock_locked_i};

  oscc_sync u_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .async_i (sy_in),
    .level_o (sy_lvl),
    .rise_o  (sy_rise)
  );

  // Field split of the synchronised vector
  assign lock     = sy_lvl[0];
  assign pll_ok   = sy_lvl[2:1];
  assign ph_lock  = sy_lvl[4:3];
  assign fr_lock  = sy_lvl[6:5];
  assign hitless  = sy_lvl[8:7];
  assign muted    = sy_lvl[10:9];
  assign pin_all  = sy_lvl[11];
  assign pin_ch   = sy_lvl[13:12];
  assign ref_rise = sy_rise[15:14];

  // ==========================================================
  // Reference alignment timers, one per channel
  for (genvar g = 0; g < 2; g++) begin : g_tmr
    oscc_align_timer u_tmr (
      .clk_i   (clk_i),
      .rst_i   (rst_i),
      .start_i (t_start[g]),
      .done_o  (t_done[g])
    );
  end

  // ==========================================================
  // Bus slave, staging and sequencers in one next-state block
  always_comb begin
    next_s   = s;
    t_start  = 2'b00;
    upd      = 1'b0;
    rearm    = 2'b00;
    rd       = 8'h00;
    mlvl     = 2'b00;
    mrise    = 2'b00;
    rcf      = 2'b00;
    ev       = 2'b00;
    auto_t   = 2'b00;
    trig     = 2'b00;
    prot     = '0;
    acc      = wb_cyc_i & wb_stb_i & ~s.ack;
    wr       = acc & wb_we_i & wb_sel_i[0];
    idx      = wb_adr_i[15:2];
    busy[0]  = s.st[0] != oscc_pkg::ST_IDLE;
    busy[1]  = s.st[1] != oscc_pkg::ST_IDLE;
    ref_any  = s.cfg[0][`OSCC_REFSYNC_BIT] | s.cfg[1][`OSCC_REFSYNC_BIT];
    prot_all = s.src_en & s.sync_mask;
    next_s.ack = acc;

    // Address decode; unmapped words read zero and ignore writes
    if (idx == `OSCC_CH0_CFG_IDX) begin
      rd = s.cfg_stg[0];
      if (wr) next_s.cfg_stg[0] = wb_dat_i[7:0];
    end else if (idx == `OSCC_CH1_CFG_IDX) begin
      rd = s.cfg_stg[1];
      if (wr) next_s.cfg_stg[1] = wb_dat_i[7:0];
    end else if (idx == `OSCC_GLOBAL_IDX) begin
      rd[`OSCC_SYNC_BIT] = s.glob;
      if (wr) next_s.glob = wb_dat_i[`OSCC_SYNC_BIT];
    end else if (idx == `OSCC_CH0_CTRL_IDX) begin
      rd[`OSCC_SYNC_BIT] = s.chsync[0];
      if (wr) next_s.chsync[0] = wb_dat_i[`OSCC_SYNC_BIT];
    end else if (idx == `OSCC_CH1_CTRL_IDX) begin
      rd[`OSCC_SYNC_BIT] = s.chsync[1];
      if (wr) next_s.chsync[1] = wb_dat_i[`OSCC_SYNC_BIT];
    end else if (idx == `OSCC_CH0_REARM_IDX) begin
      rearm[0] = wr & wb_dat_i[`OSCC_REARM_BIT];
    end else if (idx == `OSCC_CH1_REARM_IDX) begin
      rearm[1] = wr & wb_dat_i[`OSCC_REARM_BIT];
    end else if (idx == `OSCC_UPDATE_IDX) begin
      upd = wr & wb_dat_i[`OSCC_UPDATE_BIT];
    end else if (idx == `OSCC_CH0_QRATIO_IDX) begin
      rd = s.qr_stg[0];
      if (wr) next_s.qr_stg[0] = wb_dat_i[7:0];
    end else if (idx == `OSCC_CH1_QRATIO_IDX) begin
      rd = s.qr_stg[1];
      if (wr) next_s.qr_stg[1] = wb_dat_i[7:0];
    end else if (idx == `OSCC_SRC_EN_IDX) begin
      rd = {2'h0, s.src_en};
      if (wr) next_s.src_en = wb_dat_i[5:0];
    end else if (idx == `OSCC_MASK_IDX) begin
      rd = {2'h0, s.sync_mask};
      if (wr) next_s.sync_mask = wb_dat_i[5:0];
    end else if (idx == `OSCC_STATUS_IDX) begin
      rd = {3'h0, s.first_done, s.armed, busy};
    end
    if (acc) next_s.rdat = rd;

    for (int c = 0; c < 2; c++) begin
      if (upd) begin
        next_s.cfg[c] = s.cfg_stg[c];
      end
      // pins as manual bits; global bit reaches both channels
      mlvl[c]  = s.glob | s.chsync[c] | pin_all | pin_ch[c];
      mrise[c] = (mlvl[c] & ~s.man_prev[c]) | eeprom_sync_i;
      next_s.man_prev[c] = mlvl[c];
      rcf[c] = upd & (s.qr_stg[c] != s.qr[c]) & s.first_done;
      // mode decode; immediate uses lock itself
      case (s.cfg[c][1:0])
        `OSCC_MODE_IMM:   ev[c] = lock;
        `OSCC_MODE_PHASE: ev[c] = ph_lock[c];
        `OSCC_MODE_FREQ:  ev[c] = fr_lock[c];
        default:          ev[c] = 1'b0;
      endcase
      // zero mode never fires; lock first
      auto_t[c] = s.armed[c] & (s.cfg[c][1:0] != `OSCC_MODE_OFF)
                  & lock & ev[c];
      trig[c] = lock & ~busy[c] & (mrise[c] | rcf[c] | auto_t[c]);
      if (s.reconf[c]) prot[c] = prot_all[c*3 +: 3];

      case (s.st[c])
        oscc_pkg::ST_IDLE: begin
          if (trig[c]) begin
            next_s.manual[c] = mrise[c];
            next_s.reconf[c] = rcf[c] & ~mrise[c] & ~auto_t[c];
            if (auto_t[c]) next_s.armed[c] = 1'b0;
            next_s.st[c] = oscc_pkg::ST_HITLESS;
          end
        end
        oscc_pkg::ST_HITLESS: begin
          if (!ref_any || hitless[c]) next_s.st[c] = oscc_pkg::ST_MUTE;
        end
        oscc_pkg::ST_MUTE: begin
          next_s.mute[c*3 +: 3] = s.mute[c*3 +: 3] | ~prot[c];
          next_s.st[c] = oscc_pkg::ST_CONFIRM;
        end
        oscc_pkg::ST_CONFIRM: begin
          if (muted[c]) begin
            next_s.prst[c] = 1'b1;
            next_s.qrst[c*3 +: 3] = s.qrst[c*3 +: 3] | ~prot[c];
            next_s.st[c] = oscc_pkg::ST_RESET;
          end
        end
        oscc_pkg::ST_RESET: begin
          // New ratio loads while the dividers are held
          next_s.qr[c] = s.qr_stg[c];
          next_s.st[c] = oscc_pkg::ST_RELEASE;
        end
        oscc_pkg::ST_RELEASE: begin
          // manual stall; clear of the bit
          if (!s.manual[c] || !mlvl[c]) next_s.st[c] = oscc_pkg::ST_ANALOG_UPCONVERSION_PLL;
        end
        oscc_pkg::ST_ANALOG_UPCONVERSION_PLL: begin
          // analog PLL ready; own channel gating only
          if (pll_ok[c]) begin
            if (s.cfg[c][`OSCC_REFSYNC_BIT]) begin
              next_s.st[c] = oscc_pkg::ST_EDGE;
            end else begin
              next_s.st[c] = oscc_pkg::ST_UNMUTE;
            end
          end
        end
        oscc_pkg::ST_EDGE: begin
          if (ref_rise[c]) begin
            t_start[c]   = 1'b1;
            next_s.st[c] = oscc_pkg::ST_ALIGN;
          end
        end
        oscc_pkg::ST_ALIGN: begin
          if (t_done[c]) next_s.st[c] = oscc_pkg::ST_UNMUTE;
        end
        oscc_pkg::ST_UNMUTE: begin
          next_s.mute[c*3 +: 3] = s.mute[c*3 +: 3] & prot[c];
          next_s.qrst[c*3 +: 3] = s.qrst[c*3 +: 3] & prot[c];
          next_s.prst[c] = 1'b0;
          next_s.first_done = 1'b1;
          next_s.st[c] = oscc_pkg::ST_IDLE;
        end
        default: begin
          next_s.st[c] = oscc_pkg::ST_IDLE;
        end
      endcase
      // rearm write or mode rewrite; set wins over a same-cycle fire
      if (rearm[c] || (upd && (s.cfg_stg[c][1:0] != s.cfg[c][1:0]))) begin
        next_s.armed[c] = 1'b1;
      end
    end
  end

  // dividers and drivers held from reset
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s      <= '0;
      s.mute <= '1;
      s.qrst <= '1;
      s.prst <= '1;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================
  // Outputs, all from state flops
  assign wb_dat_o            = {24'h0, s.rdat};
  assign wb_ack_o            = s.ack;
  assign clock_output_mute_o = s.mute;
  assign p_div_reset_o       = s.prst;
  assign q_div_reset_o       = s.qrst;
  assign q_ratio0_o          = s.qr[0];
  assign q_ratio1_o          = s.qr[1];
  assign seq_busy_o          = busy;

  // ==========================================================
  // Assertions
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence mute_seen0;
    s.st[0] == oscc_pkg::ST_CONFIRM && muted[0];
  endsequence
  sequence edge_seen0;
    s.st[0] == oscc_pkg::ST_EDGE && ref_rise[0];
  endsequence

  q_hold_a:
    assert property (!s.first_done |-> &q_div_reset_o)
    else $error("Divider released before first sync");
  lock_gate_a:
    assert property ((s.st[0] == oscc_pkg::ST_IDLE && !lock)
                     |=> s.st[0] == oscc_pkg::ST_IDLE)
    else $error("Sequence started without system clock lock");
  mute_reset_a:
    assert property (mute_seen0 |=> p_div_reset_o[0]
                     && &(clock_output_mute_o[2:0] | $past(prot[0]))
                     && &(q_div_reset_o[2:0] | $past(prot[0])))
    else $error("Dividers not reset after mute confirm");
  reset_cause_a:
    assert property ($rose(p_div_reset_o[0]) |-> $past(muted[0]))
    else $error("Divider reset before drivers muted");
  man_stall_a:
    assert property ((s.st[0] == oscc_pkg::ST_RELEASE && s.manual[0]
                      && mlvl[0]) |=> s.st[0] == oscc_pkg::ST_RELEASE)
    else $error("Manual sequence passed a held sync bit");
  pll_wait_a:
    assert property ((s.st[0] == oscc_pkg::ST_ANALOG_UPCONVERSION_PLL && !pll_ok[0])
                     |=> s.st[0] == oscc_pkg::ST_ANALOG_UPCONVERSION_PLL)
    else $error("Release without analog PLL ready");
  align_time_a:
    assert property (edge_seen0 |=> (s.st[0] == oscc_pkg::ST_ALIGN)[*8]
                     ##1 s.st[0] == oscc_pkg::ST_UNMUTE)
    else $error("Reference alignment delay wrong");
  one_shot_a:
    assert property ((s.st[0] == oscc_pkg::ST_IDLE && trig[0] && auto_t[0]
                      && !rearm[0] && !upd) |=> !s.armed[0])
    else $error("Autosync stayed armed after firing");
  reconf_first_a:
    assert property ($rose(s.reconf[0]) |-> $past(s.first_done))
    else $error("Autoreconfig before first sync");
  global_both_a:
    assert property (($rose(s.glob) && !busy[0] && !busy[1] && lock
                      && !s.man_prev[0] && !s.man_prev[1])
                     |=> busy[0] && busy[1])
    else $error("Global sync did not start both channels");
endmodule
